// ==== verilog/tape_order_termination_status.sv ====
// Order termination, error accumulation, interrupts and readiness of a tape controller.
//
// Local design decisions: the APB interface to the registers and the address map.
`include "tape_term_map.svh"

// Contract
// R1 - Finished order reports channel end and/or unusual end with gathered errors.
// R2 - Errors keep accumulating across chained orders.
// R3 - Error halt in order-out cycle: no channel end, unusual end.
// R4 - Backward read or space at load point: unusual end, no channel end.
// R5 - Write or tape mark to protected device: unusual end, no channel end.
// R6 - Error halt gives unusual end, except halt in terminal order after order-in.
// R7 - Tape mark seen during read gives unusual end.
// R8 - Space record over tape mark ends with unusual end.
// R9 - Station leaving automatic after motion began gives unusual end, rewinds exempt.
// R10 - Controller and station return ready after unusual end or terminal halt.
// R11 - Read or write end flags transmission error on rate or data error.
// R12 - Data error holds parity errors; CRC mismatch counts only on reads.
// R13 - Incorrect length on reads when count done and record end differ.
// R14 - Terminal order interrupt bit raises controller interrupt for last device.
// R15 - Device interrupt at load point after rewind-interrupt or attention then automatic.
// R16 - Device may operate only with all five readiness states true.
// R17 - Station goes manual on reset switch, lost operational, rewind offline.
// R18 - Start accepted in manual mode; controller stays busy until automatic.
// R19 - Station ready when operational and not busy, either mode.
// R20 - Controller busy from start accepted until released in order-in.
// R21 - Writes end on count done; reads on count done or record gap.
// R22 - Parity checked on read data and read-after-write data.
// R23 - Odd parity over nine bits, check characters excluded.
// R24 - Errors cleared by a start that does not continue a chain.
module tape_order_termination_status (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Tape station pins
  input wire logic st_operational,
  input wire logic st_start_sw,
  input wire logic st_reset_sw,
  input wire logic st_busy,
  input wire logic st_load_point,
  input wire logic st_write_prot,
  input wire logic st_addr_ok,
  input wire logic st_attention,
  input wire logic st_tape_mark,
  input wire logic st_gap,
  input wire logic st_rate_err,
  input wire logic st_lrc_err,
  input wire logic st_crc_err,
  input wire logic st_byte_strobe,
  input wire logic st_check_char,
  input wire logic [8:0] st_data,
  // Status outputs
  output logic channel_end,
  output logic unusual_end,
  output logic ctrl_interrupt,
  output logic device_interrupt,
  output logic ctrl_busy,
  output logic may_operate,
  output logic station_manual,
  output logic transfer_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [`TT_SYNC_W-1:0] sync_a, sync_b, sync_d;
  wire [`TT_SYNC_W-1:0] pins = {st_data, st_check_char, st_byte_strobe, st_crc_err,
    st_lrc_err, st_rate_err, st_gap, st_tape_mark, st_attention, st_addr_ok,
    st_write_prot, st_load_point, st_busy, st_reset_sw, st_start_sw, st_operational};
  genvar gi;
  generate
    for (gi = 0; gi < `TT_SYNC_W; gi = gi + 1)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
          sync_d[gi] <= 1'b0;
        end
        else
        begin
          sync_a[gi] <= pins[gi];
          sync_b[gi] <= sync_a[gi];
          sync_d[gi] <= sync_b[gi];
        end
      end
    end
  endgenerate
  wire [`TT_SYNC_W-1:0] rise = sync_b & ~sync_d;
  wire s_oper = sync_b[0];
  wire s_busy = sync_b[3];
  wire s_lp = sync_b[4];
  wire s_wp = sync_b[5];
  wire s_addr = sync_b[6];
  wire start_e = rise[1];
  wire reset_e = rise[2];
  wire attn_e = rise[7];
  wire tm_e = rise[8];
  wire gap_e = rise[9];
  wire rate_e = rise[10];
  wire lrc_e = rise[11];
  wire crc_e = rise[12];
  wire byte_e = rise[13];
  wire s_chk = sync_b[14];
  wire [8:0] s_data = sync_b[23:15];

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  tape_term_pkg::ctrl_state_t state;
  tape_term_pkg::ctrl_state_t next_state;
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite && pready;
  wire hit_cmd = paddr == `TT_OFS_CMD;
  wire hit_host = paddr == `TT_OFS_HOST;
  wire hit_stat = paddr == `TT_OFS_STAT;
  wire hit_clr = paddr == `TT_OFS_INTCLR;
  wire mapped = hit_cmd || hit_host || hit_stat || hit_clr;
  wire host_cd = wr && hit_host && pwdata[`TT_HOST_CD];
  wire host_halt = wr && hit_host && pwdata[`TT_HOST_HALT];
  wire host_rel = wr && hit_host && pwdata[`TT_HOST_REL];
  wire start_io_command = wr && hit_cmd && state == tape_term_pkg::st_ready;
  wire clr_ctrl = wr && hit_clr && pwdata[`TT_INT_CTRL];
  wire clr_dev = wr && hit_clr && pwdata[`TT_INT_DEV];

  // ----------------------------------------------------------------
  // Order decode
  // ----------------------------------------------------------------
  logic [3:0] order;
  logic chain;
  logic int_bit;
  logic [3:0] last_dev;
  wire [3:0] new_ord = pwdata[3:0];
  wire [3:0] ord = start_io_command ? new_ord : order;
  wire is_read = ord == `TT_ORD_RD_FWD || ord == `TT_ORD_RD_BWD;
  wire is_wr_data = ord == `TT_ORD_WR;
  wire is_write = is_wr_data || ord == `TT_ORD_WR_TM;
  wire is_srec = ord == `TT_ORD_SR_FWD || ord == `TT_ORD_SR_BWD;
  wire is_sfile = ord == `TT_ORD_SF_FWD || ord == `TT_ORD_SF_BWD;
  wire is_back = ord == `TT_ORD_RD_BWD || ord == `TT_ORD_SR_BWD || ord == `TT_ORD_SF_BWD;
  wire is_rew = ord == `TT_ORD_REW || ord == `TT_ORD_REW_INT || ord == `TT_ORD_REW_OFF;
  wire is_instant = !(is_read || is_write || is_srec || is_sfile);

  // ----------------------------------------------------------------
  // Station mode and readiness
  // ----------------------------------------------------------------
  logic rew_pend, attn_pend, tm_seen, data_err, rate_err, trans_err, incorrect_len;
  wire auto_mode = !station_manual;
  wire dev_ready = s_oper && !s_busy; // R19
  wire reject = (is_back && s_lp) || (is_write && s_wp); // R4 R5
  wire can_begin = auto_mode && (start_io_command || state == tape_term_pkg::st_wait_auto);
  wire run = state == tape_term_pkg::st_run;
  wire lost_auto = run && !auto_mode && !is_rew; // R9
  wire halt_run = run && host_halt; // R3
  wire tm_now = run && tm_e && (is_read || is_srec);
  wire fin_norm = run && ((is_wr_data && host_cd) || (is_read && (host_cd || gap_e)) // R21
    || ((is_srec || ord == `TT_ORD_WR_TM) && gap_e)
    || (is_sfile && (tm_e || (is_back && s_lp))) || is_instant);
  wire fin = halt_run || lost_auto || fin_norm;
  wire rej_now = can_begin && reject;
  wire ue_now = halt_run || lost_auto || tm_seen || tm_now; // R6 R7 R8
  wire par_e = byte_e && !s_chk && !(^s_data); // R23
  wire err_win = run && (is_read || is_write);
  wire data_e = err_win && (par_e || lrc_e || (is_read && crc_e)); // R12 R22
  wire rate_now = err_win && rate_e;
  wire rew_off_fin = fin && ord == `TT_ORD_REW_OFF;
  wire to_manual = reset_e || !s_oper || rew_off_fin; // R17
  wire dev_int_set = (rew_pend && s_lp && dev_ready)
    || (attn_pend && start_e && s_oper && s_lp && dev_ready); // R15
  wire fresh = start_io_command && !pwdata[`TT_CMD_CHAIN];

  always_comb
  begin
    next_state = state;
    unique case (state)
      tape_term_pkg::st_ready:
        if (start_io_command)
          next_state = !auto_mode ? tape_term_pkg::st_wait_auto // R18
            : reject ? tape_term_pkg::st_order_in : tape_term_pkg::st_run;
      tape_term_pkg::st_wait_auto:
        if (auto_mode)
          next_state = reject ? tape_term_pkg::st_order_in : tape_term_pkg::st_run;
      tape_term_pkg::st_run:
        if (fin)
          next_state = tape_term_pkg::st_order_in;
      tape_term_pkg::st_order_in:
        if (host_rel || host_halt)
          next_state = tape_term_pkg::st_ready; // R10 R20
    endcase
  end

  // ----------------------------------------------------------------
  // Controller state and order latch
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= tape_term_pkg::st_ready;
      order <= 4'h0;
      chain <= 1'b0;
      int_bit <= 1'b0;
      last_dev <= 4'h0;
    end
    else
    begin
      state <= next_state;
      if (start_io_command)
      begin
        order <= new_ord;
        chain <= pwdata[`TT_CMD_CHAIN];
        int_bit <= pwdata[`TT_CMD_INT];
        last_dev <= pwdata[`TT_CMD_DEV_LO+3:`TT_CMD_DEV_LO];
      end
    end
  end

  // ----------------------------------------------------------------
  // Termination report and error accumulation
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      channel_end <= 1'b0;
      unusual_end <= 1'b0;
      tm_seen <= 1'b0;
      data_err <= 1'b0;
      rate_err <= 1'b0;
      trans_err <= 1'b0;
      incorrect_len <= 1'b0;
    end
    else
    begin
      if (rej_now)
      begin
        channel_end <= 1'b0; // R4 R5
        unusual_end <= 1'b1;
      end
      else if (start_io_command)
      begin
        channel_end <= 1'b0;
        unusual_end <= 1'b0;
        tm_seen <= 1'b0;
      end
      else if (fin)
      begin
        channel_end <= !halt_run; // R1 R3
        unusual_end <= ue_now;
      end
      else if (tm_now)
        tm_seen <= 1'b1;
      if (fresh)
      begin
        data_err <= 1'b0; // R24
        rate_err <= 1'b0;
        trans_err <= 1'b0;
        incorrect_len <= 1'b0;
      end
      else
      begin
        data_err <= data_err || data_e; // R2
        rate_err <= rate_err || rate_now;
        if (fin && (is_read || is_write) && (data_err || rate_err || data_e || rate_now))
          trans_err <= 1'b1; // R11
        if (fin_norm && is_read && (host_cd != gap_e))
          incorrect_len <= 1'b1; // R13
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode, interrupts and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      station_manual <= `TT_RST_MANUAL;
      rew_pend <= 1'b0;
      attn_pend <= 1'b0;
      ctrl_interrupt <= 1'b0;
      device_interrupt <= 1'b0;
      ctrl_busy <= 1'b0;
      may_operate <= 1'b0;
      transfer_active <= 1'b0;
    end
    else
    begin
      if (to_manual)
        station_manual <= 1'b1; // R17
      else if (start_e)
        station_manual <= 1'b0;
      rew_pend <= dev_int_set ? 1'b0 : (rew_pend || (fin && ord == `TT_ORD_REW_INT));
      attn_pend <= dev_int_set ? 1'b0 : (attn_pend || attn_e);
      ctrl_interrupt <= ((fin || rej_now) && (start_io_command ? pwdata[`TT_CMD_INT] : int_bit))
        || (ctrl_interrupt && !clr_ctrl); // R14
      device_interrupt <= dev_int_set || (device_interrupt && !clr_dev);
      ctrl_busy <= next_state != tape_term_pkg::st_ready; // R20
      may_operate <= s_addr && s_oper && !to_manual && auto_mode && dev_ready
        && next_state == tape_term_pkg::st_ready; // R16
      transfer_active <= next_state == tape_term_pkg::st_run && (is_read || is_write);
    end
  end

  wire [31:0] stat_word = {14'h0, rate_err, data_err, last_dev, 2'h0, dev_ready, auto_mode,
    may_operate, device_interrupt, ctrl_interrupt, incorrect_len, trans_err, unusual_end,
    channel_end, ctrl_busy};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite && hit_stat) ? stat_word : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_halt_in_run; state == tape_term_pkg::st_run && host_halt; endsequence
  sequence s_rejected; unusual_end && !channel_end; endsequence
  property p_halt_run;
    s_halt_in_run |=> s_rejected ##0 state == tape_term_pkg::st_order_in;
  endproperty
  a_halt_run: assert property (p_halt_run) else $error("halt in run kept channel end"); // R3
  property p_reject; (can_begin && reject) |=> s_rejected; endproperty
  a_reject: assert property (p_reject) else $error("rejected order lacks unusual end"); // R4
  property p_busy; start_io_command |=> ctrl_busy; endproperty
  a_busy: assert property (p_busy) else $error("accepted start left controller ready"); // R20
  property p_release;
    (state == tape_term_pkg::st_order_in && (host_rel || host_halt)) |=> !ctrl_busy;
  endproperty
  a_release: assert property (p_release) else $error("release did not ready controller"); // R10
  property p_len;
    (fin_norm && is_read && host_cd && !gap_e && !fresh) |=> incorrect_len;
  endproperty
  a_len: assert property (p_len) else $error("incorrect length missed"); // R13
  property p_fresh; fresh |=> !data_err && !trans_err && !incorrect_len; endproperty
  a_fresh: assert property (p_fresh) else $error("errors kept over new chain"); // R24
  property p_chain; (data_err && !fresh) |=> data_err; endproperty
  a_chain: assert property (p_chain) else $error("error lost between orders"); // R2
  property p_manual; reset_e |=> station_manual [*2]; endproperty
  a_manual: assert property (p_manual) else $error("reset switch left automatic"); // R17
  property p_wait;
    (start_io_command && !auto_mode && !start_e) |=> state == tape_term_pkg::st_wait_auto;
  endproperty
  a_wait: assert property (p_wait) else $error("manual start not held busy"); // R18
  property p_oper; may_operate |-> $past(s_oper) && auto_mode && !ctrl_busy; endproperty
  a_oper: assert property (p_oper) else $error("may operate without readiness"); // R16
endmodule

// ==== verilog/tape_term_map.svh ====
// Register offsets, field positions, reset values and order codes of the termination block.
`ifndef TAPE_TERM_MAP_SVH
`define TAPE_TERM_MAP_SVH
`define TT_OFS_CMD 8'h00
`define TT_OFS_HOST 8'h04
`define TT_OFS_STAT 8'h08
`define TT_OFS_INTCLR 8'h0c
`define TT_CMD_CHAIN 4
`define TT_CMD_INT 5
`define TT_CMD_DEV_LO 8
`define TT_HOST_CD 0
`define TT_HOST_HALT 1
`define TT_HOST_REL 2
`define TT_INT_CTRL 0
`define TT_INT_DEV 1
`define TT_SYNC_W 24
`define TT_RST_MANUAL 1'b1
`define TT_ORD_RD_FWD 4'h0
`define TT_ORD_RD_BWD 4'h1
`define TT_ORD_WR 4'h2
`define TT_ORD_WR_TM 4'h3
`define TT_ORD_SR_FWD 4'h4
`define TT_ORD_SR_BWD 4'h5
`define TT_ORD_SF_FWD 4'h6
`define TT_ORD_SF_BWD 4'h7
`define TT_ORD_REW 4'h8
`define TT_ORD_REW_INT 4'h9
`define TT_ORD_REW_OFF 4'ha
`endif

// ==== verilog/tape_term_pkg.sv ====
// Types shared by the tape order termination block.
package tape_term_pkg;
  typedef enum logic [1:0] {
    st_ready = 2'b00,
    st_wait_auto = 2'b01,
    st_run = 2'b10,
    st_order_in = 2'b11
  } ctrl_state_t;
endpackage

// ==== test/tape_station_model.sv ====
// Behavioural tape station that drives the station pins of the termination block.
module tape_station_model (
  // Clock
  input wire logic pclk,
  // Station levels
  output logic st_operational,
  output logic st_busy,
  output logic st_load_point,
  output logic st_write_prot,
  output logic st_addr_ok,
  output logic st_check_char,
  output logic [8:0] st_data,
  // Station events
  output logic st_start_sw,
  output logic st_reset_sw,
  output logic st_attention,
  output logic st_tape_mark,
  output logic st_gap,
  output logic st_rate_err,
  output logic st_lrc_err,
  output logic st_crc_err,
  output logic st_byte_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] ev = 9'h000;
  logic [8:0] byte_q = 9'h000;
  logic [8:0] idle_pat = 9'h0aa;
  logic drive = 1'b0;
  assign {st_byte_strobe, st_crc_err, st_lrc_err, st_rate_err, st_gap, st_tape_mark,
    st_attention, st_reset_sw, st_start_sw} = ev;
  // The data lines toggle while no byte is offered, so a stale byte is never sampled.
  assign st_data = drive ? byte_q : idle_pat;
  always @(posedge pclk) idle_pat <= ~idle_pat;
  initial {st_operational, st_busy, st_load_point, st_write_prot, st_addr_ok} = 5'b10001;
  initial st_check_char = 1'b0;
  task automatic set_lvl(input logic [4:0] v);
    @(posedge pclk);
    {st_operational, st_busy, st_load_point, st_write_prot, st_addr_ok} <= v;
  endtask
  // Events stay three clocks high and three low, longer than the synchroniser needs.
  task automatic pulse(input int n);
    logic [8:0] m;
    m = 9'h001 << n;
    @(posedge pclk);
    ev <= ev | m;
    repeat (3) @(posedge pclk);
    ev <= ev & ~m;
    repeat (3) @(posedge pclk);
  endtask
  // A byte carries odd parity over nine bits unless bad asks for a parity fault.
  task automatic send_byte(input logic [7:0] d, input logic bad, input logic chk);
    @(posedge pclk);
    byte_q <= {~^d ^ bad, d};
    drive <= 1'b1;
    st_check_char <= chk;
    repeat (3) @(posedge pclk);
    pulse(8);
    drive <= 1'b0;
    st_check_char <= 1'b0;
  endtask
endmodule

// ==== test/test_tape_order_termination_status.sv ====
// Self-checking bench of the tape order termination block.
`include "tape_term_map.svh"
`define CHK(g, e) check(32'(g), 32'(e));
module test_tape_order_termination_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic channel_end, unusual_end, ctrl_interrupt, device_interrupt;
  logic ctrl_busy, may_operate, station_manual, transfer_active;
  logic st_operational, st_busy, st_load_point, st_write_prot, st_addr_ok, st_check_char;
  logic st_start_sw, st_reset_sw, st_attention, st_tape_mark, st_gap, st_rate_err;
  logic st_lrc_err, st_crc_err, st_byte_strobe;
  logic [8:0] st_data;
  logic [3:0] dev, o;
  logic [4:0] lvl;
  logic [3:0] ords [5] = '{`TT_ORD_RD_BWD, `TT_ORD_SR_BWD, `TT_ORD_SF_BWD, `TT_ORD_WR,
    `TT_ORD_WR_TM};
  logic [3:0] tm_ords [3] = '{`TT_ORD_RD_FWD, `TT_ORD_SR_FWD, `TT_ORD_SR_BWD};
  int fails = 0;
  int num_checks = 0;

  tape_order_termination_status tape_order_termination_status_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .st_operational(st_operational), .st_start_sw(st_start_sw), .st_reset_sw(st_reset_sw),
    .st_busy(st_busy), .st_load_point(st_load_point), .st_write_prot(st_write_prot),
    .st_addr_ok(st_addr_ok), .st_attention(st_attention), .st_tape_mark(st_tape_mark),
    .st_gap(st_gap), .st_rate_err(st_rate_err), .st_lrc_err(st_lrc_err),
    .st_crc_err(st_crc_err), .st_byte_strobe(st_byte_strobe), .st_check_char(st_check_char),
    .st_data(st_data), .channel_end(channel_end), .unusual_end(unusual_end),
    .ctrl_interrupt(ctrl_interrupt), .device_interrupt(device_interrupt),
    .ctrl_busy(ctrl_busy), .may_operate(may_operate), .station_manual(station_manual),
    .transfer_active(transfer_active));
  tape_station_model station_i (.pclk(pclk), .st_operational(st_operational),
    .st_busy(st_busy), .st_load_point(st_load_point), .st_write_prot(st_write_prot),
    .st_addr_ok(st_addr_ok), .st_check_char(st_check_char), .st_data(st_data),
    .st_start_sw(st_start_sw), .st_reset_sw(st_reset_sw), .st_attention(st_attention),
    .st_tape_mark(st_tape_mark), .st_gap(st_gap), .st_rate_err(st_rate_err),
    .st_lrc_err(st_lrc_err), .st_crc_err(st_crc_err), .st_byte_strobe(st_byte_strobe));

  initial forever #4 pclk = ~pclk;

  // --------------------------------------------------------------------------
  // Bench tasks
  // --------------------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic stat();
    apb(1'b0, `TT_OFS_STAT, 32'h0);
  endtask
  task automatic start(input logic [3:0] ord, input logic ch, input logic ib);
    apb(1'b1, `TT_OFS_CMD, {20'h0, dev, 2'b00, ib, ch, ord});
  endtask
  task automatic done_order(input logic halt);
    apb(1'b1, `TT_OFS_HOST, halt ? 32'h2 : 32'h4);
    repeat (2) @(posedge pclk);
    `CHK(ctrl_busy, 1'b0)
  endtask
  // Returns unusual end and channel end for an order given load point and protection.
  function automatic logic [1:0] ends_exp(input logic [3:0] ord, input logic lp, input logic wp);
    if (lp && (ord == `TT_ORD_RD_BWD || ord == `TT_ORD_SR_BWD || ord == `TT_ORD_SF_BWD))
      return 2'b10;
    if (wp && (ord == `TT_ORD_WR || ord == `TT_ORD_WR_TM))
      return 2'b10;
    return 2'b01;
  endfunction

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    void'($urandom(5084));
    dev = 4'($urandom_range(15));
    repeat (10) @(posedge pclk);
    `CHK({channel_end, unusual_end, ctrl_busy, station_manual}, 4'h1)
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, 8'h10, 32'h0);
    `CHK(err, 1'b1)
    start(`TT_ORD_RD_FWD, 1'b0, 1'b0);
    repeat (8) @(posedge pclk);
    `CHK({ctrl_busy, transfer_active}, 2'b10)
    station_i.pulse(0);
    `CHK({station_manual, transfer_active}, 2'b01)
    repeat ($urandom_range(4, 1)) station_i.send_byte(8'($urandom), 1'b0, 1'b0);
    station_i.pulse(4);
    `CHK({unusual_end, channel_end}, ends_exp(`TT_ORD_RD_FWD, 0, 0))
    stat();
    `CHK({rd[16], rd[4:3], rd[15:12]}, {3'b010, dev})
    done_order(1'b1);
    `CHK({unusual_end, may_operate}, 2'b01)
    station_i.set_lvl(5'b10000);
    repeat (6) @(posedge pclk);
    `CHK(may_operate, 1'b0)
    station_i.set_lvl(5'b10001);
    start(`TT_ORD_RD_FWD, 1'b0, 1'b0);
    station_i.send_byte(8'($urandom), 1'b1, 1'b0);
    apb(1'b1, `TT_OFS_HOST, 32'h1);
    repeat (3) @(posedge pclk);
    `CHK({channel_end, transfer_active}, 2'b10)
    stat();
    `CHK({rd[16], rd[4:3]}, 3'b111)
    done_order(1'b0);
    start(`TT_ORD_RD_FWD, 1'b1, 1'b0);
    station_i.pulse(4);
    stat();
    `CHK({rd[16], rd[3]}, 2'b11)
    done_order(1'b0);
    start(`TT_ORD_RD_FWD, 1'b0, 1'b0);
    station_i.send_byte(8'($urandom), 1'b1, 1'b1);
    stat();
    `CHK(rd[16], 1'b0)
    station_i.pulse(7);
    station_i.pulse(4);
    stat();
    `CHK({rd[16], rd[3]}, 2'b11)
    done_order(1'b0);
    for (int i = 0; i < 5; i++)
    begin
      lvl = (i < 3) ? 5'b10101 : 5'b10011;
      o = ords[i];
      station_i.set_lvl(lvl);
      start(o, 1'b0, 1'b0);
      repeat (6) @(posedge pclk);
      `CHK({unusual_end, channel_end}, ends_exp(o, lvl[2], lvl[1]))
      done_order(1'b1);
    end
    station_i.set_lvl(5'b10001);
    start(`TT_ORD_WR, 1'b0, 1'b0);
    repeat (6) @(posedge pclk);
    apb(1'b1, `TT_OFS_HOST, 32'h2);
    repeat (3) @(posedge pclk);
    `CHK({unusual_end, channel_end}, 2'b10)
    done_order(1'b0);
    for (int i = 0; i < 3; i++)
    begin
      start(tm_ords[i], 1'b0, 1'b0);
      station_i.pulse(3);
      station_i.pulse(4);
      `CHK({unusual_end, channel_end}, 2'b11)
      done_order(1'b0);
    end
    start(`TT_ORD_WR, 1'b0, 1'b0);
    station_i.send_byte(8'($urandom), 1'b0, 1'b0);
    station_i.pulse(7);
    station_i.pulse(5);
    apb(1'b1, `TT_OFS_HOST, 32'h1);
    repeat (3) @(posedge pclk);
    `CHK({unusual_end, channel_end}, 2'b01)
    stat();
    `CHK({rd[17:16], rd[4:3]}, 4'b1001)
    done_order(1'b0);
    start(`TT_ORD_RD_FWD, 1'b0, 1'b0);
    repeat (6) @(posedge pclk);
    station_i.pulse(1);
    `CHK({station_manual, unusual_end, channel_end}, 3'b111)
    done_order(1'b0);
    stat();
    `CHK(rd[9], 1'b1)
    station_i.set_lvl(5'b11001);
    repeat (6) @(posedge pclk);
    stat();
    `CHK(rd[9], 1'b0)
    station_i.set_lvl(5'b10001);
    station_i.pulse(0);
    start(`TT_ORD_REW_OFF, 1'b0, 1'b0);
    repeat (6) @(posedge pclk);
    `CHK(station_manual, 1'b1)
    done_order(1'b0);
    station_i.pulse(0);
    start(`TT_ORD_REW_INT, 1'b0, 1'b1);
    repeat (6) @(posedge pclk);
    `CHK({ctrl_interrupt, device_interrupt}, 2'b10)
    done_order(1'b0);
    station_i.set_lvl(5'b10101);
    repeat (6) @(posedge pclk);
    stat();
    `CHK({rd[6:5], rd[15:12]}, {2'b11, dev})
    apb(1'b1, `TT_OFS_INTCLR, 32'h3);
    repeat (2) @(posedge pclk);
    `CHK({ctrl_interrupt, device_interrupt}, 2'b00)
    station_i.pulse(1);
    station_i.pulse(2);
    station_i.pulse(0);
    `CHK(device_interrupt, 1'b1)
    conclude();
  end

  initial
  begin
    #400000;
    fails++;
    conclude();
  end
endmodule
